// *** core/scbor_consts.svh ***
// Offsets, field positions, resets and timing counts of the brown-out slice.
`ifndef SCBOR_CONSTS_SVH
`define SCBOR_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCBOR_ADDR_W 12
`define SCBOR_OFS_CAP_ONE 12'h010
`define SCBOR_OFS_CAP_PINS 12'h018
`define SCBOR_OFS_CAP_PORTS 12'h01C
`define SCBOR_OFS_BOR_CTL 12'h030
`define SCBOR_OFS_VREG_CTL 12'h034
`define SCBOR_OFS_SWRST0 12'h040
`define SCBOR_OFS_BO_STATUS 12'h050
`define SCBOR_OFS_BO_MASK 12'h054
`define SCBOR_OFS_RUN_GATE2 12'h108
`define SCBOR_OFS_SLEEP_GATE2 12'h118
`define SCBOR_OFS_DSLEEP_GATE2 12'h128

// ****************************************************************
// Fixed capability words and reset values
// ****************************************************************
`define SCBOR_CAP_ONE_VAL 32'h0000901F
`define SCBOR_CAP_PINS_VAL 32'h810003C0
`define SCBOR_CAP_PORTS_VAL 32'h00000007
`define SCBOR_BOR_CNT_RST 14'h1FFF
`define SCBOR_SWRST0_IMPL 32'h00000008
`define SCBOR_ZERO32 32'h00000000

// ****************************************************************
// Field positions
// ****************************************************************
`define SCBOR_BOR_CNT_HI 15
`define SCBOR_BOR_CNT_LO 2
`define SCBOR_BOR_CNT_W 14
`define SCBOR_BOR_SEL_BIT 1
`define SCBOR_BOR_WAIT_BIT 0
`define SCBOR_VSEL_HI 5
`define SCBOR_VSEL_W 6
`define SCBOR_WDT_BIT 3
`define SCBOR_BO_EVT_BIT 1
`define SCBOR_GATE_W 3

// ****************************************************************
// Timing and bus answers
// ****************************************************************
`define SCBOR_SYS_CLK_KHZ 250000
`define SCBOR_BOOT_OSCILLATOR_KHZ 15000
`define SCBOR_BOOT_OSCILLATOR_DIV (`SCBOR_SYS_CLK_KHZ / `SCBOR_BOOT_OSCILLATOR_KHZ)
`define SCBOR_RESP_OKAY 2'h0
`define SCBOR_RESP_SLVERR 2'h2

`endif

// *** core/scbor_pkg.sv ***
// Types shared by the brown-out and capability slice.
package scbor_pkg;

  typedef enum logic [3:0] {
    SCBOR_SEL_NONE,
    SCBOR_SEL_CAP_ONE,
    SCBOR_SEL_CAP_PINS,
    SCBOR_SEL_CAP_PORTS,
    SCBOR_SEL_BOR_CTL,
    SCBOR_SEL_VREG_CTL,
    SCBOR_SEL_SWRST0,
    SCBOR_SEL_BO_STATUS,
    SCBOR_SEL_BO_MASK,
    SCBOR_SEL_RUN_GATE2,
    SCBOR_SEL_SLEEP_GATE2,
    SCBOR_SEL_DSLEEP_GATE2
  } scbor_reg_sel_t;

  typedef enum logic [1:0] {
    SCBOR_BO_IDLE,
    SCBOR_BO_WAIT,
    SCBOR_BO_HOLD
  } scbor_bo_state_t;

endpackage

// *** core/scbor_sync2.sv ***
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps

module scbor_sync2
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** core/scbor_boot_oscillator_timer.sv ***
// Boot-oscillator tick divider and brown-out debounce down-counter.
`timescale 1ns/1ps
`include "scbor_consts.svh"

module scbor_boot_oscillator_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [`SCBOR_BOR_CNT_W-1:0] load_count,
  output logic expired
);

  localparam int DIV = `SCBOR_BOOT_OSCILLATOR_DIV;

  logic [4:0] div_cnt_r;
  logic tick;
  logic run_r;
  logic [`SCBOR_BOR_CNT_W-1:0] cnt_r;

  assign tick = (div_cnt_r == 5'(DIV - 1));

  // ****************************************************************
  // Boot-oscillator period as a one-cycle enable
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_cnt_r <= 5'h00;
    else if (tick)
      div_cnt_r <= 5'h00;
    else
      div_cnt_r <= div_cnt_r + 5'h01;
  end

  // ****************************************************************
  // Debounce count
  // ****************************************************************
  // A count of N ends on the N-th tick; a count of zero ends on the first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_r <= 1'b0;
      cnt_r <= '0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        run_r <= 1'b1;
        cnt_r <= load_count;
      end
      else if (run_r && tick)
      begin
        if (cnt_r <= `SCBOR_BOR_CNT_W'(1))
        begin
          run_r <= 1'b0;
          expired <= 1'b1;
        end
        else
          cnt_r <= cnt_r - `SCBOR_BOR_CNT_W'(1);
      end
    end
  end

endmodule

// *** core/scbor_top.sv ***
// System-control slice: capabilities, brown-out response, regulator, resets.
// Function
// R1: Pin capabilities bit 31 reads one.
// R2: Pin capabilities bit 24 reads one.
// R3: Pin capabilities bits 9 to 6 read one.
// R4: Software leaves reserved bits alone.
// R5: Port capabilities bits 2 to 0 read one.
// R6: Port capabilities mask group-two gating writes.
// R7: Debounce count bits 15:2, reset 0x1FFF.
// R8: Select bit chooses reset or interrupt.
// R9: Wait enabled: count, resample, report if asserted.
// R10: Deasserted resample is noise, nothing reported.
// R11: Wait disabled: report every assertion at once.
// R12: Six-bit voltage select drives regulator input.
// R13: Software uses only listed voltage codes.
// R14: First capability word masks reset-control writes.
// R15: Watchdog reset bit 3; bits 2:0 zero.
// R16: Masked-out write bits are forced to zero.
// R17: Interrupt needs mask set and select clear.
// R18: Watchdog held in reset while bit set.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "scbor_consts.svh"

module scbor_top
  import scbor_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SCBOR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SCBOR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic brownout_detector_output,
  output logic brownout_reset_req_r,
  output logic brownout_irq_r,
  output logic [`SCBOR_VSEL_W-1:0] regulator_select_input_r,
  output logic watchdog_reset_r,
  output logic [`SCBOR_GATE_W-1:0] run_gating_group_two_r,
  output logic [`SCBOR_GATE_W-1:0] sleep_gating_group_two_r,
  output logic [`SCBOR_GATE_W-1:0] deepsleep_gating_group_two_r
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic scbor_reg_sel_t reg_decode
  (
    input logic [`SCBOR_ADDR_W-1:0] addr
  );
    scbor_reg_sel_t sel;
    case (addr)
      `SCBOR_OFS_CAP_ONE: sel = SCBOR_SEL_CAP_ONE;
      `SCBOR_OFS_CAP_PINS: sel = SCBOR_SEL_CAP_PINS;
      `SCBOR_OFS_CAP_PORTS: sel = SCBOR_SEL_CAP_PORTS;
      `SCBOR_OFS_BOR_CTL: sel = SCBOR_SEL_BOR_CTL;
      `SCBOR_OFS_VREG_CTL: sel = SCBOR_SEL_VREG_CTL;
      `SCBOR_OFS_SWRST0: sel = SCBOR_SEL_SWRST0;
      `SCBOR_OFS_BO_STATUS: sel = SCBOR_SEL_BO_STATUS;
      `SCBOR_OFS_BO_MASK: sel = SCBOR_SEL_BO_MASK;
      `SCBOR_OFS_RUN_GATE2: sel = SCBOR_SEL_RUN_GATE2;
      `SCBOR_OFS_SLEEP_GATE2: sel = SCBOR_SEL_SLEEP_GATE2;
      `SCBOR_OFS_DSLEEP_GATE2: sel = SCBOR_SEL_DSLEEP_GATE2;
      default: sel = SCBOR_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Byte lanes not strobed keep the old value; bits outside the mask
  // are forced to zero whatever was written.
  function automatic logic [31:0] masked_write
  (
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] strb,
    input logic [31:0] mask
  );
    logic [31:0] merged;
    merged = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        merged[8*i +: 8] = wdata[8*i +: 8];
    end
    return merged & mask; // R16
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [`SCBOR_BOR_CNT_W-1:0] bo_count_r;
  logic bo_select_r;
  logic bo_wait_en_r;
  logic bo_event_r;
  logic bo_mask_r;
  logic [31:0] bor_ctl_word;
  logic [31:0] vreg_word;
  logic [31:0] swrst0_word;
  logic [31:0] status_word;
  logic [31:0] mask_word;
  logic [31:0] run_gate_word;
  logic [31:0] sleep_gate_word;
  logic [31:0] dsleep_gate_word;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  logic aw_full_r;
  logic w_full_r;
  logic [`SCBOR_ADDR_W-1:0] wr_addr_r;
  logic [31:0] wr_data_r;
  logic [3:0] wr_strb_r;
  logic wr_fire;
  scbor_reg_sel_t wr_sel;

  // Both halves held and no response pending: commit in this cycle.
  assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_sel = reg_decode(wr_addr_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_full_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_full_r <= 1'b1;
      wr_addr_r <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_full_r <= 1'b0;
    else if (!aw_full_r && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_full_r <= 1'b0;
      wr_data_r <= '0;
      wr_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_full_r <= 1'b1;
      wr_data_r <= s_axi_wdata;
      wr_strb_r <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_full_r <= 1'b0;
    else if (!w_full_r && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCBOR_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      if (wr_sel == SCBOR_SEL_NONE)
        s_axi_bresp <= `SCBOR_RESP_SLVERR;
      else
        s_axi_bresp <= `SCBOR_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    case (reg_decode(s_axi_araddr))
      SCBOR_SEL_CAP_ONE: rd_mux = `SCBOR_CAP_ONE_VAL;
      SCBOR_SEL_CAP_PINS: rd_mux = `SCBOR_CAP_PINS_VAL; // R1 R2 R3
      SCBOR_SEL_CAP_PORTS: rd_mux = `SCBOR_CAP_PORTS_VAL; // R5
      SCBOR_SEL_BOR_CTL: rd_mux = bor_ctl_word;
      SCBOR_SEL_VREG_CTL: rd_mux = vreg_word;
      SCBOR_SEL_SWRST0: rd_mux = swrst0_word;
      SCBOR_SEL_BO_STATUS: rd_mux = status_word;
      SCBOR_SEL_BO_MASK: rd_mux = mask_word;
      SCBOR_SEL_RUN_GATE2: rd_mux = run_gate_word;
      SCBOR_SEL_SLEEP_GATE2: rd_mux = sleep_gate_word;
      SCBOR_SEL_DSLEEP_GATE2: rd_mux = dsleep_gate_word;
      default: rd_mux = `SCBOR_ZERO32;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SCBOR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      if (reg_decode(s_axi_araddr) == SCBOR_SEL_NONE)
        s_axi_rresp <= `SCBOR_RESP_SLVERR;
      else
        s_axi_rresp <= `SCBOR_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ****************************************************************
  // Brown-out control register
  // ****************************************************************
  assign bor_ctl_word = {16'h0000, bo_count_r, bo_select_r, bo_wait_en_r};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bo_count_r <= `SCBOR_BOR_CNT_RST; // R7
      bo_select_r <= 1'b0; // R8
      bo_wait_en_r <= 1'b1; // R9
    end
    else if (wr_fire && wr_sel == SCBOR_SEL_BOR_CTL)
    begin
      bo_count_r <= `SCBOR_BOR_CNT_W'(masked_write(bor_ctl_word, wr_data_r,
        wr_strb_r, 32'h0000FFFF) >> `SCBOR_BOR_CNT_LO); // R7
      bo_select_r <= 1'(masked_write(bor_ctl_word, wr_data_r, wr_strb_r,
        32'h0000FFFF) >> `SCBOR_BOR_SEL_BIT); // R8
      bo_wait_en_r <= 1'(masked_write(bor_ctl_word, wr_data_r, wr_strb_r,
        32'h0000FFFF) >> `SCBOR_BOR_WAIT_BIT); // R9
    end
  end

  // ****************************************************************
  // Regulator voltage select
  // ****************************************************************
  // Reserved codes are stored and driven as written; keeping to the
  // listed codes is the job of software.
  assign vreg_word = {26'h0000000, regulator_select_input_r};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      regulator_select_input_r <= 6'h00; // R12
    else if (wr_fire && wr_sel == SCBOR_SEL_VREG_CTL)
      regulator_select_input_r <= `SCBOR_VSEL_W'(masked_write(vreg_word,
        wr_data_r, wr_strb_r, 32'h0000003F)); // R12
  end

  // ****************************************************************
  // Software reset control zero
  // ****************************************************************
  assign swrst0_word = {28'h0000000, watchdog_reset_r, 3'h0}; // R15

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      watchdog_reset_r <= 1'b0; // R18
    else if (wr_fire && wr_sel == SCBOR_SEL_SWRST0)
      watchdog_reset_r <= 1'(masked_write(swrst0_word, wr_data_r, wr_strb_r,
        `SCBOR_CAP_ONE_VAL & `SCBOR_SWRST0_IMPL) >> `SCBOR_WDT_BIT); // R14 R18
  end

  // ****************************************************************
  // Clock gating group two
  // ****************************************************************
  assign run_gate_word = {29'h00000000, run_gating_group_two_r};
  assign sleep_gate_word = {29'h00000000, sleep_gating_group_two_r};
  assign dsleep_gate_word = {29'h00000000, deepsleep_gating_group_two_r};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_gating_group_two_r <= 3'h0;
    else if (wr_fire && wr_sel == SCBOR_SEL_RUN_GATE2)
      run_gating_group_two_r <= `SCBOR_GATE_W'(masked_write(run_gate_word,
        wr_data_r, wr_strb_r, `SCBOR_CAP_PORTS_VAL)); // R6
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sleep_gating_group_two_r <= 3'h0;
    else if (wr_fire && wr_sel == SCBOR_SEL_SLEEP_GATE2)
      sleep_gating_group_two_r <= `SCBOR_GATE_W'(masked_write(sleep_gate_word,
        wr_data_r, wr_strb_r, `SCBOR_CAP_PORTS_VAL)); // R6
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      deepsleep_gating_group_two_r <= 3'h0;
    else if (wr_fire && wr_sel == SCBOR_SEL_DSLEEP_GATE2)
      deepsleep_gating_group_two_r <= `SCBOR_GATE_W'(masked_write(
        dsleep_gate_word, wr_data_r, wr_strb_r, `SCBOR_CAP_PORTS_VAL)); // R6
  end

  // ****************************************************************
  // Brown-out detection
  // ****************************************************************
  logic det_sync;
  logic timer_start;
  logic timer_expired;
  logic confirm;
  scbor_bo_state_t bo_state_r;

  scbor_sync2 u_det_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(brownout_detector_output),
    .sync_out(det_sync)
  );

  scbor_boot_oscillator_timer u_boot_oscillator_timer
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(timer_start),
    .load_count(bo_count_r),
    .expired(timer_expired)
  );

  assign timer_start = (bo_state_r == SCBOR_BO_IDLE) && det_sync
    && bo_wait_en_r; // R9

  always_comb
  begin
    case (bo_state_r)
      SCBOR_BO_IDLE: confirm = det_sync && !bo_wait_en_r; // R11
      SCBOR_BO_WAIT: confirm = timer_expired && det_sync; // R9
      default: confirm = 1'b0;
    endcase
  end

  // After a report the detector must drop before a new event is counted,
  // so a long brown-out is reported once and not on every cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bo_state_r <= SCBOR_BO_IDLE;
    else
    begin
      case (bo_state_r)
        SCBOR_BO_IDLE:
        begin
          if (timer_start)
            bo_state_r <= SCBOR_BO_WAIT;
          else if (confirm)
            bo_state_r <= SCBOR_BO_HOLD;
        end
        SCBOR_BO_WAIT:
        begin
          if (confirm)
            bo_state_r <= SCBOR_BO_HOLD;
          else if (timer_expired)
            bo_state_r <= SCBOR_BO_IDLE; // R10
        end
        SCBOR_BO_HOLD:
        begin
          if (!det_sync)
            bo_state_r <= SCBOR_BO_IDLE;
        end
        default: bo_state_r <= SCBOR_BO_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      brownout_reset_req_r <= 1'b0;
    else
      brownout_reset_req_r <= confirm && bo_select_r; // R8
  end

  // ****************************************************************
  // Brown-out event status and interrupt mask
  // ****************************************************************
  assign status_word = {30'h00000000, bo_event_r, 1'b0};
  assign mask_word = {30'h00000000, bo_mask_r, 1'b0};

  // Writing one clears the event; a new event in the same cycle wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bo_event_r <= 1'b0;
    else if (confirm && !bo_select_r)
      bo_event_r <= 1'b1; // R8
    else if (wr_fire && wr_sel == SCBOR_SEL_BO_STATUS
      && wr_strb_r[0] && wr_data_r[`SCBOR_BO_EVT_BIT])
      bo_event_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bo_mask_r <= 1'b0;
    else if (wr_fire && wr_sel == SCBOR_SEL_BO_MASK)
      bo_mask_r <= 1'(masked_write(mask_word, wr_data_r, wr_strb_r,
        32'h00000002) >> `SCBOR_BO_EVT_BIT);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      brownout_irq_r <= 1'b0;
    else
      brownout_irq_r <= bo_event_r && bo_mask_r && !bo_select_r; // R17
  end

endmodule

// *** verif/scbor_chk.sv ***
// Port-level checks of the brown-out and capability slice.
`timescale 1ns/1ps
`include "scbor_consts.svh"

module scbor_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SCBOR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [`SCBOR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic brownout_detector_output,
  input wire logic brownout_reset_req_r,
  input wire logic [`SCBOR_VSEL_W-1:0] regulator_select_input_r,
  input wire logic watchdog_reset_r,
  input wire logic [`SCBOR_GATE_W-1:0] run_gating_group_two_r
);
  logic [`SCBOR_ADDR_W-1:0] wa_r;
  logic [`SCBOR_ADDR_W-1:0] ra_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic [7:0] hist_r;

  // The last accepted addresses and data tell which register a response
  // belongs to; the detector history covers sync and resample delay.
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      {wd_r, ws_r} <= {s_axi_wdata, s_axi_wstrb};
    if (s_axi_arvalid && s_axi_arready)
      ra_r <= s_axi_araddr;
    hist_r <= {hist_r[6:0], brownout_detector_output};
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_done_s;
    $rose(s_axi_bvalid);
  endsequence

  sequence rd_done_s;
    $rose(s_axi_rvalid);
  endsequence

  pins_read_a:
    assert property ((rd_done_s ##0 ra_r == `SCBOR_OFS_CAP_PINS) |->
      (s_axi_rdata & 32'h810003C0) == 32'h810003C0)
    else $error("pin capability bits wrong");
  ports_read_a:
    assert property ((rd_done_s ##0 ra_r == `SCBOR_OFS_CAP_PORTS) |->
      s_axi_rdata[2:0] == 3'h7)
    else $error("port capability bits wrong");
  swrst_low_a:
    assert property ((rd_done_s ##0 ra_r == `SCBOR_OFS_SWRST0) |->
      s_axi_rdata[2:0] == 3'h0)
    else $error("reset control low bits not zero");
  vsel_write_a:
    assert property ((wr_done_s ##0 wa_r == `SCBOR_OFS_VREG_CTL && ws_r[0])
      |-> regulator_select_input_r == wd_r[5:0])
    else $error("voltage select not taken from write");
  vsel_hold_a:
    assert property ($changed(regulator_select_input_r) |->
      $rose(s_axi_bvalid))
    else $error("voltage select moved without a write");
  wdog_write_a:
    assert property ((wr_done_s ##0 wa_r == `SCBOR_OFS_SWRST0 && ws_r[0])
      |-> watchdog_reset_r == wd_r[3])
    else $error("watchdog reset not taken from write");
  gate_write_a:
    assert property ((wr_done_s ##0 wa_r == `SCBOR_OFS_RUN_GATE2 && ws_r[0])
      |-> run_gating_group_two_r == wd_r[2:0])
    else $error("run gating not masked write");
  reset_pulse_a:
    assert property (brownout_reset_req_r |=> !brownout_reset_req_r)
    else $error("reset request longer than one cycle");
  no_noise_a:
    assert property (brownout_reset_req_r |-> |hist_r)
    else $error("reset request without detector");
endmodule

bind scbor_top scbor_chk u_chk (.*);

// *** verif/scbor_ana_model.sv ***
// Behavioural brown-out detector and voltage regulator beside the slice.
`timescale 1ns/1ps
`include "scbor_consts.svh"

module scbor_ana_model
(
  input wire logic aclk,
  input wire logic [`SCBOR_VSEL_W-1:0] regulator_select_input_r,
  output logic brownout_detector_output
);
  int vout_mv;

  initial brownout_detector_output = 1'h0;

  // Reserved codes give -1 so that a bad setting shows at once.
  always_comb
  begin
    if (regulator_select_input_r <= 6'h05)
      vout_mv = 2500 - 50 * int'(regulator_select_input_r);
    else if (regulator_select_input_r >= 6'h1B &&
             regulator_select_input_r <= 6'h1F)
      vout_mv = 2750 - 50 * (int'(regulator_select_input_r) - 27);
    else
      vout_mv = -1;
  end

  task automatic sag(input int cycles);
    @(posedge aclk);
    brownout_detector_output <= 1'h1;
    repeat (cycles) @(posedge aclk);
    brownout_detector_output <= 1'h0;
  endtask
endmodule

// *** verif/sysctl_caps_brownout_reset_tb_top.sv ***
// Self-checking bench for the capability, brown-out and regulator slice.
`timescale 1ns/1ps
`include "scbor_consts.svh"

module sysctl_caps_brownout_reset_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, brownout_detector_output, brownout_reset_req_r;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic brownout_irq_r, watchdog_reset_r;
  logic [5:0] regulator_select_input_r;
  logic [2:0] run_gating_group_two_r, sleep_gating_group_two_r;
  logic [2:0] deepsleep_gating_group_two_r;
  logic [11:0] gate_ofs [3] = '{`SCBOR_OFS_RUN_GATE2,
    `SCBOR_OFS_SLEEP_GATE2, `SCBOR_OFS_DSLEEP_GATE2};
  int err_count = 0;
  int checked = 0;

  scbor_top u_dut (.*);
  scbor_ana_model u_ana (.*);

  initial forever #2 aclk = ~aclk;

  // ********
  // Shared tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic aw_left;
    logic w_left;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {aw_left, w_left} = 2'h3;
    while (aw_left || w_left)
    begin
      @(posedge aclk);
      aw_left = aw_left && s_axi_awready !== 1'h1;
      w_left = w_left && s_axi_wready !== 1'h1;
      s_axi_awvalid <= aw_left;
      s_axi_wvalid <= w_left;
    end
    while (s_axi_bvalid !== 1'h1)
      @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask

  // Only the bits in m are compared, so reserved positions are not relied on.
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    @(posedge aclk);
    while (s_axi_arready !== 1'h1)
      @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'h1)
      @(posedge aclk);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask

  task automatic bor(input int hold, input int span, output int rs,
                     output int ir, output int fa);
    {rs, ir, fa} = {32'd0, 32'd0, -32'd1};
    fork
      u_ana.sag(hold);
      for (int i = 0; i < span; i++)
      begin
        @(posedge aclk);
        if (brownout_reset_req_r === 1'h1 && fa < 0)
          fa = i;
        rs += int'(brownout_reset_req_r === 1'h1);
        ir += int'(brownout_irq_r === 1'h1);
      end
    join
  endtask

  initial
  begin
    #40000;
    err_count++;
    stop_test();
  end

  // ********
  // Test sequence
  // ********
  initial
  begin
    logic [5:0] code;
    int rs, ir, fa;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`SCBOR_OFS_BOR_CTL, 32'h0000FFFF, 32'h00007FFD, 2'h0);
    rd(`SCBOR_OFS_VREG_CTL, 32'h0000003F, 32'h0, 2'h0);
    wr(`SCBOR_OFS_CAP_PINS, 32'h0, 4'hF, 2'h0);
    rd(`SCBOR_OFS_CAP_PINS, 32'h810003C0, 32'h810003C0, 2'h0);
    rd(`SCBOR_OFS_CAP_PORTS, 32'h7, 32'h7, 2'h0);
    rd(12'hFFC, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(12'hFFC, 32'hFFFFFFFF, 4'hF, 2'h2);
    for (int i = 0; i < 11; i++)
    begin
      code = (i < 5) ? 6'(6'h1B + i) : 6'(i - 5);
      wr(`SCBOR_OFS_VREG_CTL, {26'h0, code}, 4'h1, 2'h0);
      chk({26'h0, regulator_select_input_r}, {26'h0, code});
      chk(32'(u_ana.vout_mv), 32'(2750 - 50 * i));
    end
    wr(`SCBOR_OFS_VREG_CTL, 32'h3F, 4'h0, 2'h0);
    rd(`SCBOR_OFS_VREG_CTL, 32'h3F, 32'h5, 2'h0);
    wr(`SCBOR_OFS_SWRST0, 32'hFFFFFFFF, 4'hF, 2'h0);
    chk({31'h0, watchdog_reset_r}, 32'h1);
    rd(`SCBOR_OFS_SWRST0, 32'hFFFFFFFF, 32'h8, 2'h0);
    wr(`SCBOR_OFS_SWRST0, 32'h0, 4'hF, 2'h0);
    chk({31'h0, watchdog_reset_r}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(gate_ofs[i], 32'hFFFFFFFF, 4'hF, 2'h0);
      rd(gate_ofs[i], 32'hFFFFFFFF, 32'h7, 2'h0);
    end
    chk({23'h0, run_gating_group_two_r, sleep_gating_group_two_r,
         deepsleep_gating_group_two_r}, 32'h1FF);
    wr(`SCBOR_OFS_BOR_CTL, 32'h2, 4'hF, 2'h0);
    bor(4, 20, rs, ir, fa);
    chk(32'(rs), 32'h1);
    chk(32'(fa < 8), 32'h1);
    wr(`SCBOR_OFS_BOR_CTL, 32'hB, 4'hF, 2'h0);
    bor(3, 100, rs, ir, fa);
    chk(32'(rs + ir), 32'h0);
    bor(80, 120, rs, ir, fa);
    chk(32'(rs), 32'h1);
    chk(32'(fa > 16 && fa < 64), 32'h1);
    wr(`SCBOR_OFS_BOR_CTL, 32'h0, 4'hF, 2'h0);
    wr(`SCBOR_OFS_BO_MASK, 32'h2, 4'hF, 2'h0);
    bor(4, 20, rs, ir, fa);
    chk(32'(rs), 32'h0);
    chk(32'(ir > 0), 32'h1);
    rd(`SCBOR_OFS_BO_STATUS, 32'h2, 32'h2, 2'h0);
    wr(`SCBOR_OFS_BO_STATUS, 32'h2, 4'hF, 2'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, brownout_irq_r}, 32'h0);
    wr(`SCBOR_OFS_BO_MASK, 32'h0, 4'hF, 2'h0);
    bor(4, 20, rs, ir, fa);
    chk(32'(ir), 32'h0);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`SCBOR_OFS_BOR_CTL, 32'h0000FFFF, 32'h00007FFD, 2'h0);
    stop_test();
  end
endmodule
